// File: hw/stream_address.sv
// Purpose: byte address pointer for streaming accesses
// Assumes: one advance pulse per byte transferred
// Notes: hold stops the step so the pointer stays at the loaded address, otherwise it moves up or down
`timescale 1ns/1ps
`default_nettype none
module stream_address
  import strobe_regs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic [11:0] startAddress,
  input wire logic advance,
  input wire logic hold,
  input wire logic ascending,
  // pointer
  output logic [11:0] address
);
  logic [11:0] next_address;

  // the start byte is itself transferred, so the step applies on top of the load
  always_comb begin
    next_address = load ? startAddress : address;
    if (advance && !hold) begin
      next_address = ascending ? next_address + 12'h001 : next_address - 12'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      address <= 12'h000;
    end else begin
      address <= next_address;
    end
  end
endmodule
`default_nettype wire

// File: hw/strobe_regs_pkg.sv
// Purpose: shared constants and types for the clock and full-scale register bank
// Assumes: byte-wide register access, 12-bit byte address
// Notes: multi-byte fields are little-endian, lowest byte at the lowest address
package strobe_regs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] USER_CONFIG_ADDR = 12'h010;
  localparam logic [11:0] CLOCK_CONTROL_PRIMARY_ADDR = 12'h029;
  localparam logic [11:0] CLOCK_CONTROL_SECONDARY_ADDR = 12'h02a;
  localparam logic [11:0] EDGE_POSITION_ADDR0 = 12'h02c;
  localparam logic [11:0] EDGE_POSITION_ADDR1 = 12'h02d;
  localparam logic [11:0] EDGE_POSITION_ADDR2 = 12'h02e;
  localparam logic [11:0] FULLSCALE_A_ADDR0 = 12'h030;
  localparam logic [11:0] FULLSCALE_A_ADDR1 = 12'h031;
  localparam logic [7:0] USER_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_PRIMARY_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_SECONDARY_RESET = 8'h00;
  localparam logic [15:0] FULLSCALE_A_RESET = 16'ha000;
  localparam logic [15:0] FULLSCALE_RECOMMENDED_MIN = 16'h2000;
  localparam logic [3:0] DELAY_SELECT_AUTO = 4'h0;
  localparam int ADDR_HOLD_BIT = 0;

  typedef struct packed {
    logic reserved;
    logic strobe_processor_enable;
    logic strobe_receiver_enable;
    logic strobe_status_fine_view;
    logic [3:0] strobe_delay_select;
  } clock_control_primary_t;

  typedef struct packed {
    logic [4:0] reserved;
    logic sample_clock_lowswing_mode;
    logic strobe_lowswing_mode;
    logic strobe_polarity_invert;
  } clock_control_secondary_t;

  typedef struct packed {
    logic start;
    logic write;
    logic read;
    logic [11:0] address;
    logic [7:0] data;
  } byte_access_t;
endpackage

// File: hw/sysref_clock_fullscale_regs.sv
// Purpose: strobe alignment, clock input mode and channel A full-scale register bank
// Assumes: serial port front end delivers byte strobes synchronous to mclk
// Notes: edge position is sampled live from the measurement logic on each read
// Summary of operation
// - the strobe processor acts on strobe events only while its enable bit is one.
// - writing one to the receiver enable bit turns the strobe receiver on.
// - the fine view bit switches the edge position readback to the fine measurement.
// - the four-bit delay select field chooses the strobe capture delay applied.
// - a delay select of zero hands strobe timing to automatic calibration.
// - the sample clock low-swing bit puts the clock receiver into low-swing mode.
// - the strobe low-swing bit puts the strobe receiver into low-swing mode.
// - the polarity bit inverts the strobe before it is used for alignment.
// - a read-only 24-bit field over three bytes reports the strobe edge position.
// - a 16-bit field sets the channel A full-scale code, resetting to 0xa000.
// - the primary clock control register at 0x029 resets to zero, strobe path off.
// - registers are reached over the serial port, with address hold or stepping.
`timescale 1ns/1ps
`default_nettype none
module sysref_clock_fullscale_regs
  import strobe_regs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // byte access from the serial port front end
  input wire byte_access_t access,
  input wire logic addressAscending,
  output logic [7:0] readData,
  output logic [11:0] currentAddress,
  // strobe path
  input wire logic strobeIn,
  input wire logic [23:0] edgePositionCoarse,
  input wire logic [23:0] edgePositionFine,
  output logic strobeEvent,
  output logic strobeReceiverOn,
  output logic [3:0] strobeDelay,
  output logic strobeAutoCalibrate,
  // analog controls
  output logic sampleClockLowSwing,
  output logic strobeLowSwing,
  output logic [15:0] channelAFullScale,
  output logic fullScaleBelowMin
);
  clock_control_primary_t primaryCtrl, next_primaryCtrl;
  clock_control_secondary_t secondaryCtrl, next_secondaryCtrl;
  logic [7:0] userConfig, next_userConfig;
  logic [15:0] fullScaleA, next_fullScaleA;
  logic [7:0] next_readData;
  logic strobeEventReg, next_strobeEvent;
  logic [23:0] edgePosition;
  logic [11:0] accessAddress;
  logic [11:0] pointer;

  // a start byte carries its own address; later bytes use the stepped pointer
  assign accessAddress = access.start ? access.address : pointer;

  stream_address addressPointer (
    .mclk(mclk),
    .reset(reset),
    .load(access.start),
    .startAddress(access.address),
    .advance(access.write || access.read),
    .hold(userConfig[ADDR_HOLD_BIT]),
    .ascending(addressAscending),
    .address(pointer)
  );

  // both measurements are offered, the fine view bit picks which one is read
  assign edgePosition = primaryCtrl.strobe_status_fine_view ? edgePositionFine
                                                             : edgePositionCoarse;

  always_comb begin
    next_primaryCtrl = primaryCtrl;
    next_secondaryCtrl = secondaryCtrl;
    next_userConfig = userConfig;
    next_fullScaleA = fullScaleA;
    if (access.write) begin
      unique case (accessAddress)
        USER_CONFIG_ADDR: next_userConfig = access.data;
        CLOCK_CONTROL_PRIMARY_ADDR: next_primaryCtrl = access.data;
        CLOCK_CONTROL_SECONDARY_ADDR: next_secondaryCtrl = access.data;
        FULLSCALE_A_ADDR0: next_fullScaleA[7:0] = access.data;
        FULLSCALE_A_ADDR1: next_fullScaleA[15:8] = access.data;
        // edge position and unmapped bytes ignore writes
        default: next_userConfig = userConfig;
      endcase
    end
  end

  always_comb begin
    next_readData = readData;
    if (access.read) begin
      unique case (accessAddress)
        USER_CONFIG_ADDR: next_readData = userConfig;
        CLOCK_CONTROL_PRIMARY_ADDR: next_readData = primaryCtrl;
        CLOCK_CONTROL_SECONDARY_ADDR: next_readData = secondaryCtrl;
        EDGE_POSITION_ADDR0: next_readData = edgePosition[7:0];
        EDGE_POSITION_ADDR1: next_readData = edgePosition[15:8];
        EDGE_POSITION_ADDR2: next_readData = edgePosition[23:16];
        FULLSCALE_A_ADDR0: next_readData = fullScaleA[7:0];
        FULLSCALE_A_ADDR1: next_readData = fullScaleA[15:8];
        default: next_readData = 8'h00;
      endcase
    end
  end

  always_comb begin
    // the receiver must be on too, so a host that sets only the processor enable bit gets nothing
    next_strobeEvent = primaryCtrl.strobe_processor_enable
                       && primaryCtrl.strobe_receiver_enable
                       && (strobeIn ^ secondaryCtrl.strobe_polarity_invert);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      primaryCtrl <= CLOCK_CONTROL_PRIMARY_RESET;
      secondaryCtrl <= CLOCK_CONTROL_SECONDARY_RESET;
      userConfig <= USER_CONFIG_RESET;
      fullScaleA <= FULLSCALE_A_RESET;
      readData <= 8'h00;
      strobeEventReg <= 1'b0;
    end else begin
      primaryCtrl <= next_primaryCtrl;
      secondaryCtrl <= next_secondaryCtrl;
      userConfig <= next_userConfig;
      fullScaleA <= next_fullScaleA;
      readData <= next_readData;
      strobeEventReg <= next_strobeEvent;
    end
  end

  assign currentAddress = pointer;
  assign strobeEvent = strobeEventReg;
  assign strobeReceiverOn = primaryCtrl.strobe_receiver_enable;
  assign strobeDelay = primaryCtrl.strobe_delay_select;
  assign strobeAutoCalibrate = (primaryCtrl.strobe_delay_select == DELAY_SELECT_AUTO);
  assign sampleClockLowSwing = secondaryCtrl.sample_clock_lowswing_mode;
  assign strobeLowSwing = secondaryCtrl.strobe_lowswing_mode;
  assign channelAFullScale = fullScaleA;
  // flag only; the code is still applied as written
  assign fullScaleBelowMin = (fullScaleA < FULLSCALE_RECOMMENDED_MIN);
endmodule
`default_nettype wire

// File: testbench/host_port_model.sv
// Purpose: host side of the byte register port
// Assumes: one byte access per call, taken at the next edge
// Notes: pulses change just after the edge, never on it
`timescale 1ns/1ps
`default_nettype none
module host_port_model import strobe_regs_pkg::*; (
  input wire logic mclk,
  output var byte_access_t access
);
  initial access = '0;
  task automatic put(input logic s, w, r, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    access = '{s, w, r, a, d};
  endtask
endmodule
`default_nettype wire

// File: testbench/sysref_clock_fullscale_regs_bench.sv
// Purpose: self-checking bench for the strobe and full-scale register bank
// Assumes: host model drives the byte port
// Notes: expected values come from fixed edge position inputs
`timescale 1ns/1ps
`default_nettype none
module sysref_clock_fullscale_regs_bench import strobe_regs_pkg::*;;
  logic mclk = 0, reset = 1, addressAscending = 1, strobeIn = 0;
  logic [23:0] edgePositionCoarse = 24'h332211, edgePositionFine = 24'h665544;
  byte_access_t access;
  logic [7:0] readData;
  logic [11:0] currentAddress;
  logic [15:0] channelAFullScale;
  logic [3:0] strobeDelay;
  logic strobeEvent, strobeReceiverOn, strobeAutoCalibrate;
  logic sampleClockLowSwing, strobeLowSwing, fullScaleBelowMin;
  int fail_count = 0, num_checks = 0, cycles = 0;
  host_port_model i_host_port_model (.mclk, .access);
  sysref_clock_fullscale_regs i_sysref_clock_fullscale_regs (.mclk, .reset, .access,
    .addressAscending, .readData, .currentAddress, .strobeIn, .edgePositionCoarse,
    .edgePositionFine, .strobeEvent, .strobeReceiverOn, .strobeDelay, .strobeAutoCalibrate,
    .sampleClockLowSwing, .strobeLowSwing, .channelAFullScale, .fullScaleBelowMin);
  initial forever #5 mclk = ~mclk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [23:0] g, e);
    num_checks++;
    if (g !== e) begin
      $display("FAIL %0t got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic put(input logic s, w, r, input logic [11:0] a, input logic [7:0] d);
    i_host_port_model.put(s, w, r, a, d);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    put(1, 1, 0, a, d);
    put(0, 0, 0, 12'h000, 8'h00);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    put(1, 0, 1, a, 8'h00);
    put(0, 0, 0, 12'h000, 8'h00);
    chk(readData, e);
  endtask
  task automatic t_reset;
    rd(12'h029, 8'h00);
    rd(12'h031, 8'ha0);
    rd(12'h02a, 8'h00);
    chk(strobeAutoCalibrate, 1);
  endtask
  task automatic t_strobe;
    wr(12'h029, 8'h20);
    chk(strobeReceiverOn, 1);
    wr(12'h029, 8'h6a);
    chk({strobeDelay, strobeAutoCalibrate}, 5'h14);
    strobeIn = 1;
    @(posedge mclk);
    #1;
    chk(strobeEvent, 1);
    wr(12'h02a, 8'h07);
    chk({sampleClockLowSwing, strobeLowSwing}, 2'b11);
    @(posedge mclk);
    #1;
    chk(strobeEvent, 0);
    strobeIn = 0;
    @(posedge mclk);
    #1;
    chk(strobeEvent, 1);
    strobeIn = 1;
    wr(12'h02a, 8'h00);
    wr(12'h029, 8'h20);
    @(posedge mclk);
    #1;
    chk(strobeEvent, 0);
    strobeIn = 0;
  endtask
  task automatic t_edge;
    put(1, 0, 1, 12'h02c, 8'h00);
    put(0, 0, 1, 12'h000, 8'h00);
    chk(readData, 8'h11);
    put(0, 0, 1, 12'h000, 8'h00);
    chk(readData, 8'h22);
    put(0, 0, 0, 12'h000, 8'h00);
    chk(readData, 8'h33);
    wr(12'h029, 8'h30);
    rd(12'h02c, 8'h44);
    wr(12'h02c, 8'hff);
    rd(12'h02c, 8'h44);
    wr(12'h029, {4'h3, readData[3:0]});
    chk(strobeDelay, 4'h4);
  endtask
  task automatic t_fullscale;
    put(1, 1, 0, 12'h030, 8'h34);
    put(0, 1, 0, 12'h000, 8'h12);
    put(0, 0, 0, 12'h000, 8'h00);
    chk({channelAFullScale, fullScaleBelowMin}, 17'h02469);
    wr(12'h031, 8'h20);
    wr(12'h030, 8'h00);
    chk({channelAFullScale, fullScaleBelowMin}, 17'h04000);
  endtask
  task automatic t_address;
    wr(12'h010, 8'h01);
    put(1, 1, 0, 12'h030, 8'h56);
    put(0, 1, 0, 12'h000, 8'h78);
    put(0, 0, 0, 12'h000, 8'h00);
    chk({channelAFullScale, currentAddress}, 28'h2078030);
    wr(12'h010, 8'h00);
    addressAscending = 0;
    put(1, 0, 1, 12'h02e, 8'h00);
    put(0, 0, 1, 12'h000, 8'h00);
    chk(readData, 8'h66);
    put(0, 0, 0, 12'h000, 8'h00);
    chk(readData, 8'h55);
    addressAscending = 1;
    rd(12'h020, 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    reset = 0;
    t_reset();
    t_strobe();
    t_edge();
    t_fullscale();
    t_address();
    final_report();
  end
endmodule
`default_nettype wire

// File: testbench/sysref_clock_fullscale_regs_chk.sv
// Purpose: port checks for the strobe and full-scale register bank
// Assumes: single clock domain
// Notes: the fine view bit is not at the ports, so edge reads accept either source
`timescale 1ns/1ps
`default_nettype none
module sysref_clock_fullscale_regs_chk import strobe_regs_pkg::*; (
  input wire logic mclk, reset, addressAscending, strobeEvent, strobeReceiverOn,
  input wire logic strobeAutoCalibrate, sampleClockLowSwing, strobeLowSwing, fullScaleBelowMin,
  input wire byte_access_t access,
  input wire logic [7:0] readData,
  input wire logic [11:0] currentAddress,
  input wire logic [23:0] edgePositionCoarse, edgePositionFine,
  input wire logic [3:0] strobeDelay,
  input wire logic [15:0] channelAFullScale
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic wrS = access.write && access.start;
  sequence s_low;
    wrS && access.address == FULLSCALE_A_ADDR0 && addressAscending;
  endsequence
  sequence s_high;
    access.write && !access.start && currentAddress == FULLSCALE_A_ADDR1;
  endsequence
  a_auto_cal: assert property (strobeAutoCalibrate == (strobeDelay == 4'h0))
    else $error("auto calibration flag wrong");
  a_fs_flag: assert property (fullScaleBelowMin == (channelAFullScale < 16'h2000))
    else $error("full-scale flag wrong");
  a_event_gate: assert property (strobeEvent |-> $past(strobeReceiverOn))
    else $error("strobe event with receiver off");
  a_ctrl_write: assert property (wrS && access.address == 12'h029 |=>
    strobeDelay == $past(access.data[3:0]) && strobeReceiverOn == $past(access.data[5]))
    else $error("primary control write lost");
  a_mode_write: assert property (wrS && access.address == 12'h02a |=>
    sampleClockLowSwing == $past(access.data[2]) && strobeLowSwing == $past(access.data[1]))
    else $error("secondary control write lost");
  a_ro_write: assert property (wrS && access.address inside {[12'h02c:12'h02e]} |=>
    $stable(channelAFullScale) && $stable(strobeDelay) && $stable(strobeLowSwing))
    else $error("edge position write had an effect");
  a_edge_read: assert property (access.read && !access.write && access.start &&
    access.address == 12'h02c |=> readData == $past(edgePositionCoarse[7:0]) ||
    readData == $past(edgePositionFine[7:0])) else $error("edge position read wrong");
  a_stream_pair: assert property (s_low ##1 s_high |=>
    channelAFullScale == {$past(access.data), $past(access.data, 2)})
    else $error("streamed full-scale write wrong");
  a_reset_vals: assert property ($fell(reset) |-> channelAFullScale == 16'ha000 &&
    strobeDelay == 4'h0 && !strobeReceiverOn && readData == 8'h00)
    else $error("reset values wrong");
endmodule
bind sysref_clock_fullscale_regs sysref_clock_fullscale_regs_chk i_chk (.mclk, .reset,
  .addressAscending, .strobeEvent, .strobeReceiverOn, .strobeAutoCalibrate,
  .sampleClockLowSwing, .strobeLowSwing, .fullScaleBelowMin, .access, .readData,
  .currentAddress, .edgePositionCoarse, .edgePositionFine, .strobeDelay, .channelAFullScale);
`default_nettype wire
